//--- verilog/mfdt_pkg.sv
`default_nettype none
package mfdt_pkg;
   localparam int          PORT_W       = 8;
   localparam int          TOT_W        = 26;
   localparam int          DAC_W        = 16;
   localparam int          DAC_CH       = 2;
   localparam int          SYNC_STAGES  = 2;
   localparam int          CLK_HZ       = 25000000;
   localparam int          PULSE_MAX_HZ = 100000;
   localparam int          PULSE_CYCLES = (CLK_HZ + PULSE_MAX_HZ - 1) / PULSE_MAX_HZ;
   localparam logic [25:0] TOT_MAX      = 26'h3ffffff;
   localparam logic [25:0] TOT_RST      = 26'h0000000;
   localparam logic [15:0] DAC_RST      = 16'h0000;
   localparam logic [7:0]  PORT_RST     = 8'hff;
   typedef enum logic [1:0]
   {
      MFDT_MODE_IN    = 2'b00,
      MFDT_MODE_OUT   = 2'b01,
      MFDT_MODE_WORD  = 2'b10
   } mfdt_mode_type;
endpackage : mfdt_pkg
`default_nettype wire

//--- verilog/mfdt_sync.sv
`default_nettype none
module mfdt_sync
   import mfdt_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '1
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // level in and out
   input  wire logic [WIDTH-1:0] asyncIn,
   output var  logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;
   // first stage feeds only the second one
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         meta_q  <= RST_VAL;
         syncOut <= RST_VAL;
      end
      else
      begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule : mfdt_sync
`default_nettype wire

//--- verilog/mfdt_top.sv
`default_nettype none
module mfdt_top
   import mfdt_pkg::*;
#(
   parameter int PW = PORT_W,
   parameter int TW = TOT_W,
   parameter int DW = DAC_W,
   parameter int NDAC = DAC_CH
)
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // digital port pins, two ports side by side
   input  wire logic [2*PW-1:0]      portIn,
   output var  logic [2*PW-1:0]      portOut,
   output var  logic [2*PW-1:0]      portOe,
   // digital port control
   input  wire logic [1:0]           portMode0,
   input  wire logic [1:0]           portMode1,
   input  wire logic [2*PW-1:0]      portWrData,
   input  wire logic                 portWrStb,
   input  wire logic                 portReadStb,
   output var  logic [2*PW-1:0]      portLive,
   output var  logic [2*PW-1:0]      portCapt,
   output var  logic                 portCaptVld,
   // alarm setup per port
   input  wire logic [2*PW-1:0]      alarmPattern,
   input  wire logic [2*PW-1:0]      alarmMask,
   input  wire logic [1:0]           alarmEnMatch,
   input  wire logic [1:0]           alarmEnChange,
   output var  logic [1:0]           alarmPulse,
   // totalizer pins and control
   input  wire logic                 totPulseIn,
   input  wire logic                 totGateHi,
   input  wire logic                 totGateLowN,
   input  wire logic                 totFallEdge,
   input  wire logic                 totClear,
   input  wire logic                 totReadStb,
   output var  logic [TW-1:0]        totCount,
   output var  logic [TW-1:0]        totCapt,
   output var  logic                 totCaptVld,
   // analog set-points
   input  wire logic [NDAC-1:0]      dacWrStb,
   input  wire logic [DW-1:0]        dacWrCode,
   output var  logic [NDAC*DW-1:0]   dacCode
);
   logic [2*PW-1:0] portSync;
   logic [2:0]      totSync;
   logic [2*PW-1:0] prevIn_q;
   logic            pulsePrev_q;
   logic            edgeSeen;
   logic            gateOk;
   logic [1:0]      warm_q;
   logic [1:0]      isOut;
   logic            wordMode;

   // pull-ups live on the board: floating pins arrive here as one
   mfdt_sync #(.WIDTH(2*PW), .RST_VAL({2*PW{1'b1}})) uPortSync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .asyncIn (portIn),
      .syncOut (portSync)
   );
   // gates reset to their enabling levels so nothing is lost at release
   mfdt_sync #(.WIDTH(3), .RST_VAL(3'h4)) uTotSync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .asyncIn ({totGateHi, totGateLowN, totPulseIn}),
      .syncOut (totSync)
   );

   assign wordMode = (portMode0 == MFDT_MODE_WORD) || (portMode1 == MFDT_MODE_WORD);
   assign isOut[0] = wordMode || (portMode0 == MFDT_MODE_OUT);
   assign isOut[1] = wordMode || (portMode1 == MFDT_MODE_OUT);

   // output drive; word mode loads all sixteen bits in one strobe
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         portOut <= {PORT_RST, PORT_RST};
         portOe  <= '0;
      end
      else
      begin
         portOe <= {{PW{isOut[1]}}, {PW{isOut[0]}}};
         if (portWrStb && wordMode)
            portOut <= portWrData;
         else if (portWrStb)
         begin
            if (isOut[0])
               portOut[PW-1:0] <= portWrData[PW-1:0];
            if (isOut[1])
               portOut[2*PW-1:PW] <= portWrData[2*PW-1:PW];
         end
      end
   end

   // live state and scan capture
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         portLive    <= {PORT_RST, PORT_RST};
         portCapt    <= {PORT_RST, PORT_RST};
         portCaptVld <= 1'b0;
      end
      else
      begin
         portLive    <= portSync;
         portCaptVld <= portReadStb;
         if (portReadStb)
            portCapt <= portSync;
      end
   end

   // alarms watch inputs all the time, not only when scanned
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         prevIn_q   <= {PORT_RST, PORT_RST};
         alarmPulse <= 2'b00;
      end
      else
      begin
         prevIn_q <= portSync;
         for (int p = 0; p < 2; p++)
         begin
            alarmPulse[p] <= !isOut[p] && (
               (alarmEnMatch[p] &&
                (((portSync[p*PW +: PW] ^ alarmPattern[p*PW +: PW]) &
                  alarmMask[p*PW +: PW]) == '0) &&
                (((prevIn_q[p*PW +: PW] ^ alarmPattern[p*PW +: PW]) &
                  alarmMask[p*PW +: PW]) != '0)) ||
               (alarmEnChange[p] &&
                (((portSync[p*PW +: PW] ^ prevIn_q[p*PW +: PW]) &
                  alarmMask[p*PW +: PW]) != '0)));
         end
      end
   end

   // totalizer
   // edges wait until pin levels fill both sync stages and the previous-level
   // register, else a pulse pin idling high fakes an edge at reset release
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         warm_q <= 2'h0;
      else if (warm_q != 2'(SYNC_STAGES + 1))
         warm_q <= warm_q + 2'h1;
   end

   assign edgeSeen = (warm_q == 2'(SYNC_STAGES + 1)) &&
                     (totFallEdge ? (pulsePrev_q && !totSync[0])
                                  : (!pulsePrev_q && totSync[0]));
   assign gateOk   = totSync[2] && !totSync[1];

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pulsePrev_q <= 1'b0;
      else
         pulsePrev_q <= totSync[0];
   end

   // 25 MHz clock samples a 100 kHz input hundreds of times per period
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         totCount <= TOT_RST[TW-1:0];
      else if (totClear)
         totCount <= TOT_RST[TW-1:0];
      else if (edgeSeen && gateOk)
      begin
         if (totCount == TOT_MAX[TW-1:0])
            totCount <= TOT_RST[TW-1:0];
         else
            totCount <= totCount + 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         totCapt    <= TOT_RST[TW-1:0];
         totCaptVld <= 1'b0;
      end
      else
      begin
         totCaptVld <= totReadStb;
         if (totReadStb)
            totCapt <= totCount;
      end
   end

   // set-point codes; the code is the 1 mV step count, two's complement
   for (genvar c = 0; c < NDAC; c++)
   begin : g_dac
      always_ff @(posedge clk)
      begin
         if (sys_rst)
            dacCode[c*DW +: DW] <= DAC_RST;
         else if (dacWrStb[c])
            dacCode[c*DW +: DW] <= dacWrCode;
      end
   end

   // checks
   sequence s_gated_edge;
      edgeSeen && gateOk && !totClear;
   endsequence

   a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
      s_gated_edge |=> totCount == (($past(totCount) == TOT_MAX[TW-1:0]) ?
                                    TOT_RST[TW-1:0] : $past(totCount) + TW'(1)))
      else $error("count did not step");
   a_count_wrap: assert property (@(posedge clk) disable iff (sys_rst)
      (s_gated_edge ##0 (totCount == TOT_MAX[TW-1:0])) |=>
         totCount == TOT_RST[TW-1:0])
      else $error("count did not wrap");
   a_gate_block: assert property (@(posedge clk) disable iff (sys_rst)
      (!gateOk && !totClear) |=> $stable(totCount))
      else $error("count moved while gated off");
   a_gate_low: assert property (@(posedge clk) disable iff (sys_rst)
      totSync[1] |-> !gateOk)
      else $error("low gate failed to block");
   a_gate_high: assert property (@(posedge clk) disable iff (sys_rst)
      !totSync[2] |-> !gateOk)
      else $error("high gate failed to block");
   a_edge_sel: assert property (@(posedge clk) disable iff (sys_rst)
      edgeSeen |-> (totSync[0] == !totFallEdge))
      else $error("wrong counting edge");
   a_tot_read: assert property (@(posedge clk) disable iff (sys_rst)
      totReadStb |=> totCaptVld && totCapt == $past(totCount))
      else $error("totalizer capture wrong");
   a_port_read: assert property (@(posedge clk) disable iff (sys_rst)
      portReadStb |=> portCaptVld && portCapt == $past(portSync))
      else $error("port capture wrong");
   a_word_out: assert property (@(posedge clk) disable iff (sys_rst)
      (portWrStb && wordMode) |=> portOut == $past(portWrData))
      else $error("word output not loaded");
   a_dac_load: assert property (@(posedge clk) disable iff (sys_rst)
      dacWrStb[0] |=> dacCode[DW-1:0] == $past(dacWrCode))
      else $error("set-point not loaded");
   a_alarm_out: assert property (@(posedge clk) disable iff (sys_rst)
      (isOut == 2'b11) |=> alarmPulse == 2'b00)
      else $error("alarm on output port");
endmodule : mfdt_top
`default_nettype wire

//--- verif/mfdt_far.sv
`default_nettype none
module mfdt_far
(
   // clock
   input  wire logic        clk,
   // contacts closed to ground, one per pin
   input  wire logic [15:0] closed,
   // device pin drive
   input  wire logic [15:0] portOut,
   input  wire logic [15:0] portOe,
   // pins seen by the device
   output var  logic [15:0] portIn,
   output var  logic        totPulseIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // driven bits read back; open bits float high, closed contacts pull low
   assign portIn = (portOe & portOut) | (~portOe & ~closed);
   initial totPulseIn = 1'b0;
   // six-cycle steps, a 12-cycle period, far faster than the 100 kHz limit at this clock
   task automatic drive(input logic v);
      repeat (6) @(negedge clk);
      totPulseIn = v;
   endtask : drive
   task automatic pulses(input int n);
      repeat (n)
      begin
         drive(1'b1);
         drive(1'b0);
      end
   endtask : pulses
endmodule : mfdt_far
`default_nettype wire

//--- verif/mfdt_top_tb.sv
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module mfdt_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import mfdt_pkg::*;
   // short count so the wrap is reachable
   localparam int TWS = 4;
   typedef struct packed {
      logic [1:0]  m0, m1;
      logic [15:0] wr, cl, oe, out, capt;
   } mfdt_row_type;
   logic            clk, sys_rst, portWrStb, portReadStb, portCaptVld, totPulseIn;
   logic            totGateHi, totGateLowN, totFallEdge, totClear, totReadStb, totCaptVld;
   logic [1:0]      portMode0, portMode1, alarmEnMatch, alarmEnChange, alarmPulse;
   logic [1:0]      dacWrStb, seen;
   logic [15:0]     portIn, portOut, portOe, portWrData, portLive, portCapt;
   logic [15:0]     alarmPattern, alarmMask, dacWrCode, closed;
   logic [TWS-1:0]  totCount, totCapt;
   logic [31:0]     dacCode;
   int              n_fail = 0, comparisons = 0, cyc = 0;
   mfdt_row_type    rows [4] = '{
      '{2'h0, 2'h0, 16'h0000, 16'h00f0, 16'h0000, 16'h0000, 16'hff0f},
      '{2'h1, 2'h0, 16'h5aa5, 16'h0000, 16'h00ff, 16'h00a5, 16'hffa5},
      '{2'h2, 2'h0, 16'h1234, 16'h0000, 16'hffff, 16'h1234, 16'h1234},
      '{2'h0, 2'h1, 16'hfe7f, 16'h0000, 16'hff00, 16'hfe00, 16'hfeff}};
   mfdt_top #(.TW(TWS)) dut
   (
      .clk(clk), .sys_rst(sys_rst), .portIn(portIn), .portOut(portOut), .portOe(portOe),
      .portMode0(portMode0), .portMode1(portMode1), .portWrData(portWrData),
      .portWrStb(portWrStb), .portReadStb(portReadStb), .portLive(portLive),
      .portCapt(portCapt), .portCaptVld(portCaptVld), .alarmPattern(alarmPattern),
      .alarmMask(alarmMask), .alarmEnMatch(alarmEnMatch), .alarmEnChange(alarmEnChange),
      .alarmPulse(alarmPulse), .totPulseIn(totPulseIn), .totGateHi(totGateHi),
      .totGateLowN(totGateLowN), .totFallEdge(totFallEdge), .totClear(totClear),
      .totReadStb(totReadStb), .totCount(totCount), .totCapt(totCapt),
      .totCaptVld(totCaptVld), .dacWrStb(dacWrStb), .dacWrCode(dacWrCode),
      .dacCode(dacCode)
   );
   mfdt_far far (.clk(clk), .closed(closed), .portOut(portOut), .portOe(portOe),
                 .portIn(portIn), .totPulseIn(totPulseIn));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) seen <= sys_rst ? 2'b00 : (seen | alarmPulse);
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      $display("counts: %0d mismatches in %0d comparisons", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   // pin edges need a few cycles to cross the synchronisers
   task automatic tcheck(input logic [TWS-1:0] exp);
      repeat (6) @(negedge clk);
      `CHK(totCount, exp)
   endtask : tcheck
   initial
   begin
      {portWrStb, portReadStb, totFallEdge, totClear, totReadStb, totGateLowN} = '0;
      {portMode0, portMode1, alarmEnMatch, alarmEnChange, dacWrStb} = '0;
      {portWrData, alarmPattern, alarmMask, dacWrCode, closed} = '0;
      totGateHi = 1'b1;
      sys_rst = 1'b1;
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      `CHK({portOut, portOe, dacCode}, {16'hffff, 16'h0000, 32'h0})
      `CHK(totCount, '0)
      $display("reset test done");
      foreach (rows[i])
      begin
         portMode0 = rows[i].m0;
         portMode1 = rows[i].m1;
         closed = rows[i].cl;
         @(negedge clk);
         portWrData = rows[i].wr;
         portWrStb = 1'b1;
         @(negedge clk);
         portWrStb = 1'b0;
         repeat (6) @(negedge clk);
         `CHK(portOe, rows[i].oe)
         `CHK(portOut & portOe, rows[i].out)
         `CHK(portLive, rows[i].capt)
         portReadStb = 1'b1;
         @(negedge clk);
         portReadStb = 1'b0;
         `CHK({portCaptVld, portCapt}, {1'b1, rows[i].capt})
         $display("port row %0d done", i);
      end
      // match only on masked bits of port0, entered by grounding six contacts
      {portMode0, portMode1, alarmMask, alarmPattern} = {4'h0, 16'h00ff, 16'h0003};
      alarmEnMatch = 2'b01;
      repeat (4) @(negedge clk);
      closed = 16'h00fc;
      repeat (8) @(negedge clk);
      `CHK(seen, 2'b01)
      // change alarm on port1 only: one more contact closes on its bit 4
      {alarmMask, alarmEnChange} = {16'h10ff, 2'b10};
      repeat (4) @(negedge clk);
      closed = 16'h10fc;
      repeat (8) @(negedge clk);
      `CHK(seen, 2'b11)
      $display("alarm test done");
      far.pulses(3);
      tcheck(4'h3);
      totGateHi = 1'b0;
      far.pulses(2);
      tcheck(4'h3);
      totGateHi = 1'b1;
      totGateLowN = 1'b1;
      far.pulses(2);
      tcheck(4'h3);
      totGateLowN = 1'b0;
      totFallEdge = 1'b1;
      far.drive(1'b1);
      tcheck(4'h3);
      far.drive(1'b0);
      tcheck(4'h4);
      totFallEdge = 1'b0;
      totReadStb = 1'b1;
      @(negedge clk);
      totReadStb = 1'b0;
      `CHK({totCaptVld, totCapt}, {1'b1, 4'h4})
      far.pulses(11);
      tcheck({TWS{1'b1}});
      far.pulses(1);
      tcheck('0);
      far.pulses(2);
      tcheck(4'h2);
      totClear = 1'b1;
      @(negedge clk);
      totClear = 1'b0;
      `CHK(totCount, 4'h0)
      $display("totalizer test done");
      {dacWrCode, dacWrStb} = {16'h8001, 2'b10};
      @(negedge clk);
      {dacWrCode, dacWrStb} = {16'h7fff, 2'b01};
      @(negedge clk);
      dacWrStb = 2'b00;
      `CHK(dacCode, 32'h80017fff)
      $display("set-point test done");
      // reset in mid-run with the pulse pin high must not fake a rising edge
      far.drive(1'b1);
      tcheck(4'h1);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      `CHK(dacCode, 32'h0)
      tcheck('0);
      $display("mid-run reset test done");
      conclude();
   end
endmodule : mfdt_top_tb
`default_nettype wire
